// ### cpms_pkg.sv
// Package of constants for the privilege mode and mask state block
package cpms_pkg;
	localparam int          DATA_W        = 32;
	localparam int          EXC_W         = 9;
	localparam int          PRIO_W        = 9;
	localparam int          NUM_REGS      = 16;
	localparam int          NUM_LOW       = 8;
	localparam logic [3:0]  SP_IDX        = 4'hD;
	localparam logic [3:0]  LINK_IDX      = 4'hE;
	localparam logic [3:0]  IP_IDX        = 4'hF;
	// APB byte addresses
	localparam logic [7:0]  ADDR_PSW      = 8'h00;
	localparam logic [7:0]  ADDR_INTERRUPT_PRIORITY_MASK  = 8'h04;
	localparam logic [7:0]  ADDR_FLTMASK  = 8'h08;
	localparam logic [7:0]  ADDR_THRESH   = 8'h0C;
	localparam logic [7:0]  ADDR_CTRL     = 8'h10;
	localparam logic [7:0]  ADDR_MSP      = 8'h14;
	localparam logic [7:0]  ADDR_PSP      = 8'h18;
	localparam logic [7:0]  ADDR_ASP      = 8'h1C;
	localparam logic [7:0]  ADDR_LINK     = 8'h20;
	localparam logic [7:0]  ADDR_IP       = 8'h24;
	localparam logic [7:0]  ADDR_STATE    = 8'h28;
	localparam logic [7:0]  ADDR_FLAGS    = 8'h2C;
	localparam logic [7:0]  ADDR_EXCV     = 8'h30;
	localparam logic [7:0]  ADDR_EXEV     = 8'h34;
	// General register read window, word index in address bits 5 to 2
	localparam logic [7:0]  ADDR_GPR      = 8'h40;
	localparam logic [7:0]  GPR_WIN_MASK  = 8'hC3;
	// Status word field masks
	localparam logic [31:0] FLAGS_MASK    = 32'hF800_0000;
	localparam logic [31:0] EXC_MASK      = 32'h0000_01FF;
	localparam logic [31:0] EXEC_MASK     = 32'h0600_FC00;
	localparam int          TBIT_POS      = 24;
	localparam logic [31:0] TBIT_MASK     = 32'h0100_0000;
	localparam logic [31:0] PSW_RESET     = 32'h0100_0000;
	// Control register fields
	localparam int          CTRL_USER     = 0;
	localparam int          CTRL_ALT      = 1;
	localparam logic [31:0] SP_ALIGN      = 32'hFFFF_FFFC;
	localparam logic [31:0] IP_ALIGN      = 32'hFFFF_FFFE;
	localparam logic [8:0]  EXC_NMI       = 9'h002;
	localparam logic [8:0]  EXC_HARD      = 9'h003;
	// Fault cause codes
	localparam logic [1:0]  FLT_NONE      = 2'h0;
	localparam logic [1:0]  FLT_PRIV      = 2'h1;
	localparam logic [1:0]  FLT_TBIT      = 2'h2;
	typedef enum logic [2:0] {
		CPMS_PRIV_THREAD = 3'b001,
		CPMS_USER_THREAD = 3'b010,
		CPMS_PRIV_HANDLER = 3'b100
	} cpms_state_t;
endpackage

// ### cpms_mask.sv
// Interrupt acceptance filter from the three masks
`timescale 1ns/1ps
`default_nettype none
module cpms_mask
	import cpms_pkg::*;
(
	input  wire logic [EXC_W-1:0]  req_num,
	input  wire logic [PRIO_W-1:0] req_prio,
	input  wire logic              interrupt_priority_mask,
	input  wire logic              fltmask,
	input  wire logic [PRIO_W-1:0] thresh,
	output logic                   accept
);
	// Non-maskable bypasses every mask; hard fault bypasses all levels except the fault mask
	always_comb begin
		if (req_num == EXC_NMI) begin
			accept = 1'b1;
		end else if (fltmask) begin
			accept = 1'b0;
		end else if (req_num == EXC_HARD) begin
			accept = 1'b1;
		end else if (interrupt_priority_mask) begin
			accept = 1'b0;
		end else if (thresh != '0 && req_prio >= thresh) begin
			accept = 1'b0;
		end else begin
			accept = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### cpms_core.sv
// Privilege mode, stack banking, status views and masking state
`timescale 1ns/1ps
`default_nettype none
module cpms_core
	import cpms_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  wire logic                  exc_entry,
	input  wire logic                  exc_return,
	input  wire logic [EXC_W-1:0]      exc_num,
	input  wire logic                  call_valid,
	input  wire logic [31:0]           call_return,
	input  wire logic                  ip_load,
	input  wire logic [31:0]           ip_value,
	input  wire logic                  gpr_we,
	input  wire logic [3:0]            gpr_idx,
	input  wire logic [31:0]           gpr_wdata,
	input  wire logic                  gpr_short,
	input  wire logic                  restricted_access,
	input  wire logic [EXC_W-1:0]      irq_num,
	input  wire logic [PRIO_W-1:0]     irq_prio,
	output logic                       irq_accept_ff,
	output logic                       fault_ff,
	output logic [1:0]                 fault_cause_ff,
	output logic                       privileged_ff,
	output logic                       handler_ff,
	output logic [31:0]                active_stack_pointer_ff,
	output logic [31:0]                instruction_pointer_ff
);
	import cpms_pkg::*;

	cpms_state_t          state_ff;
	cpms_state_t          saved_state_ff;
	logic [1:0]           saved_ctrl_ff;
	logic [31:0]          regs_ff [NUM_REGS];
	logic [31:0]          main_stack_pointer_ff;
	logic [31:0]          process_stack_pointer_ff;
	logic [31:0]          return_link_ff;
	logic [31:0]          ip_ff;
	logic [31:0]          psw_ff;
	logic [EXC_W-1:0]     saved_exc_ff;
	logic                 interrupt_priority_mask_ff;
	logic                 fltmask_ff;
	logic [PRIO_W-1:0]    thresh_ff;
	logic [1:0]           ctrl_ff;
	logic                 accept;
	logic                 use_psp;
	logic                 bus_wr;
	logic                 bus_rd;
	logic                 bus_done;
	logic                 is_priv;
	logic                 tbit_clear;
	logic                 gpr_ok;
	logic [31:0]          rd_data;
	logic                 rd_hit;
	logic [31:0]          wmask;

	// Byte lane expansion of the write strobes
	function automatic logic [31:0] lanes(input logic [3:0] s);
		lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Merge write data into a register under byte lanes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// Bus phase decode; a transfer completes where pready is sampled high
	assign bus_done = psel && penable && pready;
	assign bus_wr  = bus_done && pwrite;
	assign bus_rd  = psel && penable && !pwrite;
	assign wmask   = lanes(pstrb);
	assign is_priv = (state_ff != CPMS_USER_THREAD);
	// Process stack only in thread mode with alternate bit set
	assign use_psp = (state_ff != CPMS_PRIV_HANDLER) && ctrl_ff[CTRL_ALT];
	assign tbit_clear = bus_wr && paddr == ADDR_PSW && pstrb[3] && !pwdata[TBIT_POS];
	// Short encodings reach only the low registers; link and instruction pointer writes do not check it
	assign gpr_ok = !gpr_short || (gpr_idx < 4'(NUM_LOW));

	cpms_mask u_mask (
		.req_num  (irq_num),
		.req_prio (irq_prio),
		.interrupt_priority_mask  (interrupt_priority_mask_ff),
		.fltmask  (fltmask_ff),
		.thresh   (thresh_ff),
		.accept   (accept)
	);

	// Mode state and saved context across exceptions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff       <= CPMS_PRIV_THREAD;
			saved_state_ff <= CPMS_PRIV_THREAD;
			saved_ctrl_ff  <= 2'h0;
		end else if (exc_entry) begin
			saved_state_ff <= state_ff;
			saved_ctrl_ff  <= ctrl_ff;
			state_ff       <= CPMS_PRIV_HANDLER;
		end else if (exc_return && state_ff == CPMS_PRIV_HANDLER) begin
			state_ff <= saved_state_ff;
		end else if (state_ff != CPMS_PRIV_HANDLER) begin
			state_ff <= ctrl_ff[CTRL_USER] ? CPMS_USER_THREAD : CPMS_PRIV_THREAD;
		end
	end

	// Control register; user level cannot raise privilege back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 2'h0;
		end else if (exc_entry) begin
			ctrl_ff[CTRL_ALT] <= 1'b0;
		end else if (exc_return && state_ff == CPMS_PRIV_HANDLER) begin
			ctrl_ff <= saved_ctrl_ff;
		end else if (bus_wr && paddr == ADDR_CTRL && pstrb[0] && is_priv) begin
			ctrl_ff[CTRL_USER] <= pwdata[CTRL_USER];
			ctrl_ff[CTRL_ALT]  <= (state_ff == CPMS_PRIV_HANDLER) ? 1'b0 : pwdata[CTRL_ALT];
		end
	end

	// Mask registers, writable only when privileged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_priority_mask_ff <= 1'b0;
			fltmask_ff <= 1'b0;
			thresh_ff  <= '0;
		end else if (bus_wr && is_priv && pstrb[0]) begin
			if (paddr == ADDR_INTERRUPT_PRIORITY_MASK) begin
				interrupt_priority_mask_ff <= pwdata[0];
			end
			if (paddr == ADDR_FLTMASK) begin
				fltmask_ff <= pwdata[0];
			end
			if (paddr == ADDR_THRESH && pstrb[1]) begin
				thresh_ff <= pwdata[PRIO_W-1:0];
			end
		end
	end

	// Status word views; exception number from entry, flags by bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psw_ff       <= PSW_RESET;
			saved_exc_ff <= '0;
		end else if (exc_entry) begin
			saved_exc_ff <= psw_ff[EXC_W-1:0];
			psw_ff       <= (psw_ff & ~EXC_MASK) | {23'h0, exc_num};
		end else if (exc_return && state_ff == CPMS_PRIV_HANDLER) begin
			psw_ff <= (psw_ff & ~EXC_MASK) | {23'h0, saved_exc_ff};
		end else if (bus_wr && (is_priv || paddr == ADDR_FLAGS)) begin
			// Flags view stays writable at user level
			if (paddr == ADDR_PSW && is_priv) begin
				psw_ff <= merge(psw_ff, pwdata, wmask & (FLAGS_MASK | EXEC_MASK)) | TBIT_MASK;
			end else if (paddr == ADDR_FLAGS) begin
				psw_ff <= merge(psw_ff, pwdata, wmask & FLAGS_MASK);
			end else if (paddr == ADDR_EXEV) begin
				psw_ff <= merge(psw_ff, pwdata, wmask & EXEC_MASK) | TBIT_MASK;
			end
		end
	end

	// Banked stack pointers, word aligned on every write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_stack_pointer_ff    <= 32'h0000_0000;
			process_stack_pointer_ff <= 32'h0000_0000;
		end else if (gpr_we && gpr_idx == SP_IDX && gpr_ok) begin
			if (use_psp) begin
				process_stack_pointer_ff <= gpr_wdata & SP_ALIGN;
			end else begin
				main_stack_pointer_ff <= gpr_wdata & SP_ALIGN;
			end
		end else if (bus_wr && is_priv && paddr == ADDR_MSP) begin
			main_stack_pointer_ff <= merge(main_stack_pointer_ff, pwdata, wmask) & SP_ALIGN;
		end else if (bus_wr && is_priv && paddr == ADDR_PSP) begin
			process_stack_pointer_ff <= merge(process_stack_pointer_ff, pwdata, wmask) & SP_ALIGN;
		end
	end

	// Return link and instruction pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_link_ff <= 32'h0000_0000;
			ip_ff          <= 32'h0000_0000;
		end else begin
			if (call_valid) begin
				return_link_ff <= call_return;
			end else if (gpr_we && gpr_idx == LINK_IDX) begin
				return_link_ff <= gpr_wdata;
			end
			if (ip_load) begin
				ip_ff <= ip_value & IP_ALIGN;
			end else if (gpr_we && gpr_idx == IP_IDX) begin
				ip_ff <= gpr_wdata & IP_ALIGN;
			end
		end
	end

	// General registers zero to twelve, 32 bits each
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_gpr
			if (gi < 13) begin : g_real
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						regs_ff[gi] <= 32'h0000_0000;
					end else if (gpr_we && gpr_ok && gpr_idx == 4'(gi)) begin
						regs_ff[gi] <= gpr_wdata;
					end
				end
			end else begin : g_alias
				assign regs_ff[gi] = 32'h0000_0000;
			end
		end
	endgenerate

	// Read mux across all views
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (paddr)
			ADDR_PSW:     rd_data = psw_ff | TBIT_MASK;
			ADDR_INTERRUPT_PRIORITY_MASK: rd_data = {31'h0, interrupt_priority_mask_ff};
			ADDR_FLTMASK: rd_data = {31'h0, fltmask_ff};
			ADDR_THRESH:  rd_data = {23'h0, thresh_ff};
			ADDR_CTRL:    rd_data = {30'h0, ctrl_ff};
			ADDR_MSP:     rd_data = main_stack_pointer_ff;
			ADDR_PSP:     rd_data = process_stack_pointer_ff;
			ADDR_ASP:     rd_data = use_psp ? process_stack_pointer_ff : main_stack_pointer_ff;
			ADDR_LINK:    rd_data = return_link_ff;
			ADDR_IP:      rd_data = ip_ff;
			ADDR_STATE:   rd_data = {29'h0, state_ff};
			ADDR_FLAGS:   rd_data = psw_ff & FLAGS_MASK;
			ADDR_EXCV:    rd_data = psw_ff & EXC_MASK;
			ADDR_EXEV:    rd_data = (psw_ff & EXEC_MASK) | TBIT_MASK;
			default: begin
				// General registers by word index; unmatched addresses error
				if ((paddr & GPR_WIN_MASK) == ADDR_GPR) begin
					rd_data = regs_ff[paddr[5:2]];
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	// APB answer; one wait cycle, error on unmapped or user access other than the flags view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !rd_hit || (!is_priv && paddr != ADDR_FLAGS);
			prdata  <= (bus_rd && rd_hit && (is_priv || paddr == ADDR_FLAGS)) ? rd_data : 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Fault flag: user-level restricted use or non-flags bus access, or execution bit clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff       <= 1'b0;
			fault_cause_ff <= FLT_NONE;
		end else if (!is_priv && (restricted_access || (bus_done && paddr != ADDR_FLAGS))) begin
			fault_ff       <= 1'b1;
			fault_cause_ff <= FLT_PRIV;
		end else if (tbit_clear && is_priv) begin
			fault_ff       <= 1'b1;
			fault_cause_ff <= FLT_TBIT;
		end else begin
			fault_ff       <= 1'b0;
			fault_cause_ff <= FLT_NONE;
		end
	end

	// Registered status outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_accept_ff           <= 1'b0;
			privileged_ff           <= 1'b1;
			handler_ff              <= 1'b0;
			active_stack_pointer_ff <= 32'h0000_0000;
			instruction_pointer_ff  <= 32'h0000_0000;
		end else begin
			irq_accept_ff           <= accept;
			privileged_ff           <= is_priv;
			handler_ff              <= (state_ff == CPMS_PRIV_HANDLER);
			active_stack_pointer_ff <= (use_psp ? process_stack_pointer_ff : main_stack_pointer_ff) & SP_ALIGN;
			instruction_pointer_ff  <= ip_ff & IP_ALIGN;
		end
	end

	// Handler mode never at user level
	user_no_handler_a: assert property (@(posedge pclk) disable iff (!presetn)
		handler_ff |-> privileged_ff) else $error("handler at user level");
	// Entry leads to handler two edges later
	entry_handler_a: assert property (@(posedge pclk) disable iff (!presetn)
		exc_entry |-> ##2 handler_ff) else $error("no handler after entry");
	// Stack pointer output aligned
	sp_align_a: assert property (@(posedge pclk) disable iff (!presetn)
		active_stack_pointer_ff[1:0] == 2'h0) else $error("stack pointer misaligned");
	// Instruction pointer aligned
	ip_align_a: assert property (@(posedge pclk) disable iff (!presetn)
		!instruction_pointer_ff[0]) else $error("instruction pointer misaligned");
	// Execution bit always set
	tbit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		psw_ff[TBIT_POS]) else $error("execution bit cleared");
	// Fault mask blocks hard fault
	fault_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fltmask_ff && irq_num == EXC_HARD && $stable(fltmask_ff)) |=> !irq_accept_ff)
		else $error("hard fault accepted under fault mask");
	// Non-maskable always taken
	nmi_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_num == EXC_NMI) |=> irq_accept_ff) else $error("nmi not accepted");
	// Threshold blocks equal priority
	thresh_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(thresh_ff != '0 && irq_prio == thresh_ff && irq_num > EXC_HARD) |=> !irq_accept_ff)
		else $error("threshold failed to block");
	// Call loads return link
	call_link_a: assert property (@(posedge pclk) disable iff (!presetn)
		call_valid |=> return_link_ff == $past(call_return)) else $error("return link not loaded");
	// Entry loads exception number
	sequence entry_s;
		exc_entry && !exc_return;
	endsequence
	exc_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		entry_s |=> psw_ff[EXC_W-1:0] == $past(exc_num)) else $error("exception number not loaded");
	// User-level restricted access faults
	user_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!is_priv && restricted_access) |=> fault_ff) else $error("user access not faulted");
endmodule
`default_nettype wire

// ### test_cpu_privilege_mode_and_mask_state.sv
// Self-checking bench for the privilege mode and mask state core
`timescale 1ns/1ps
`default_nettype none
module test_cpu_privilege_mode_and_mask_state;
	import cpms_pkg::*;

	typedef struct packed {
		logic              pm;
		logic              fm;
		logic [PRIO_W-1:0] th;
		logic [EXC_W-1:0]  num;
		logic [PRIO_W-1:0] prio;
		logic              acc;
	} cpms_row_t;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [3:0]        pstrb;
	logic              pready;
	logic [31:0]       prdata;
	logic              pslverr;
	logic              exc_entry;
	logic              exc_return;
	logic [EXC_W-1:0]  exc_num;
	logic              call_valid;
	logic [31:0]       call_return;
	logic              ip_load;
	logic [31:0]       ip_value;
	logic              gpr_we;
	logic [3:0]        gpr_idx;
	logic [31:0]       gpr_wdata;
	logic              gpr_short;
	logic              restricted_access;
	logic [EXC_W-1:0]  irq_num;
	logic [PRIO_W-1:0] irq_prio;
	logic              irq_accept_ff;
	logic              fault_ff;
	logic [1:0]        fault_cause_ff;
	logic              privileged_ff;
	logic              handler_ff;
	logic [31:0]       active_stack_pointer_ff;
	logic [31:0]       instruction_pointer_ff;
	logic [31:0]       rd;
	logic              er;
	logic [1:0]        seen_cause;
	int                n_errors;
	int                compares;
	cpms_row_t         rows [9];

	cpms_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.exc_entry(exc_entry), .exc_return(exc_return), .exc_num(exc_num), .call_valid(call_valid),
		.call_return(call_return), .ip_load(ip_load), .ip_value(ip_value), .gpr_we(gpr_we),
		.gpr_idx(gpr_idx), .gpr_wdata(gpr_wdata), .gpr_short(gpr_short), .restricted_access(restricted_access),
		.irq_num(irq_num), .irq_prio(irq_prio), .irq_accept_ff(irq_accept_ff), .fault_ff(fault_ff),
		.fault_cause_ff(fault_cause_ff), .privileged_ff(privileged_ff), .handler_ff(handler_ff),
		.active_stack_pointer_ff(active_stack_pointer_ff), .instruction_pointer_ff(instruction_pointer_ff));

	// Free-running core clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Remembers the cause of the latest fault pulse
	always @(posedge pclk) begin
		if (fault_ff === 1'b1)
			seen_cause <= fault_cause_ff;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			n_errors++;
			$display("[FAIL] pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One core-side register write pulse
	task automatic gpr_put(input logic [3:0] i, input logic s, input logic [31:0] d);
		@(posedge pclk);
		gpr_we <= 1'b1;
		gpr_idx <= i;
		gpr_short <= s;
		gpr_wdata <= d;
		@(posedge pclk);
		gpr_we <= 1'b0;
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#100000;
		n_errors++;
		final_report();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{exc_entry, exc_return, exc_num, call_valid, call_return, ip_load, ip_value} = '0;
		{gpr_we, gpr_idx, gpr_wdata, gpr_short} = '0;
		{restricted_access, irq_num, irq_prio, seen_cause, n_errors, compares} = '0;
		presetn = 1'b0;
		// Mask settings beside the expected acceptance
		rows[0] = '{1'b0, 1'b0, 9'h000, 9'h010, 9'h005, 1'b1};
		rows[1] = '{1'b1, 1'b0, 9'h000, 9'h010, 9'h005, 1'b0};
		rows[2] = '{1'b1, 1'b0, 9'h000, EXC_HARD, 9'h000, 1'b1};
		rows[3] = '{1'b1, 1'b0, 9'h000, EXC_NMI, 9'h000, 1'b1};
		rows[4] = '{1'b0, 1'b1, 9'h000, EXC_HARD, 9'h000, 1'b0};
		rows[5] = '{1'b0, 1'b1, 9'h000, EXC_NMI, 9'h000, 1'b1};
		rows[6] = '{1'b0, 1'b0, 9'h004, 9'h010, 9'h004, 1'b0};
		rows[7] = '{1'b0, 1'b0, 9'h004, 9'h010, 9'h005, 1'b0};
		rows[8] = '{1'b0, 1'b0, 9'h004, 9'h010, 9'h003, 1'b1};
		repeat (20) @(posedge pclk);
		chk("reset privileged", 32'h1, {31'h0, privileged_ff});
		chk("reset handler", 32'h0, {31'h0, handler_ff});
		chk("reset stack", 32'h0, active_stack_pointer_ff);
		presetn <= 1'b1;
		apb(ADDR_PSW, 1'b0, 32'h0, 4'hF);
		chk("status word reset", PSW_RESET, rd);
		apb(ADDR_STATE, 1'b0, 32'h0, 4'hF);
		chk("state privileged thread", 32'h1, rd);
		// Mask table walk
		foreach (rows[k]) begin
			apb(ADDR_INTERRUPT_PRIORITY_MASK, 1'b1, {31'h0, rows[k].pm}, 4'hF);
			apb(ADDR_FLTMASK, 1'b1, {31'h0, rows[k].fm}, 4'hF);
			apb(ADDR_THRESH, 1'b1, {23'h0, rows[k].th}, 4'hF);
			apb(ADDR_THRESH, 1'b0, 32'h0, 4'hF);
			chk("threshold readback", {23'h0, rows[k].th}, rd);
			apb(ADDR_INTERRUPT_PRIORITY_MASK, 1'b0, 32'h0, 4'hF);
			chk("priority mask readback", {31'h0, rows[k].pm}, rd);
			@(posedge pclk);
			irq_num <= rows[k].num;
			irq_prio <= rows[k].prio;
			tick(2);
			chk("irq accept", {31'h0, rows[k].acc}, {31'h0, irq_accept_ff});
		end
		apb(ADDR_THRESH, 1'b1, 32'h0, 4'hF);
		// Clearing the execution bit through byte three faults
		apb(ADDR_PSW, 1'b1, 32'h0, 4'h8);
		tick(3);
		chk("exec bit fault cause", {30'h0, FLT_TBIT}, {30'h0, seen_cause});
		apb(ADDR_PSW, 1'b1, 32'hF900_0000, 4'hF);
		apb(ADDR_PSW, 1'b0, 32'h0, 4'hF);
		chk("status word combined", 32'hF900_0000, rd);
		apb(ADDR_FLAGS, 1'b0, 32'h0, 4'hF);
		chk("flags view", 32'hF800_0000, rd);
		apb(ADDR_EXEV, 1'b1, 32'h0600_FC00, 4'hF);
		apb(ADDR_EXEV, 1'b0, 32'h0, 4'hF);
		chk("execution view", 32'h0700_FC00, rd);
		apb(8'h80, 1'b0, 32'h0, 4'hF);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		// Call and jump side inputs
		@(posedge pclk);
		call_valid <= 1'b1;
		call_return <= 32'h0000_4443;
		ip_load <= 1'b1;
		ip_value <= 32'h0000_1235;
		@(posedge pclk);
		call_valid <= 1'b0;
		ip_load <= 1'b0;
		tick(2);
		chk("instruction pointer", 32'h0000_1234, instruction_pointer_ff);
		apb(ADDR_LINK, 1'b0, 32'h0, 4'hF);
		chk("return link", 32'h0000_4443, rd);
		// Short encodings refused at register nine, accepted at register three
		gpr_put(4'h9, 1'b1, 32'hAAAA_0009);
		apb(ADDR_GPR | 8'h24, 1'b0, 32'h0, 4'hF);
		chk("high register short refused", 32'h0, rd);
		gpr_put(4'h3, 1'b1, 32'h5555_0003);
		apb(ADDR_GPR | 8'h0C, 1'b0, 32'h0, 4'hF);
		chk("low register short", 32'h5555_0003, rd);
		gpr_put(4'h9, 1'b0, 32'h1234_5678);
		apb(ADDR_GPR | 8'h24, 1'b0, 32'h0, 4'hF);
		chk("high register long", 32'h1234_5678, rd);
		// Stack banking and user level
		apb(ADDR_MSP, 1'b1, 32'h2000_0003, 4'hF);
		apb(ADDR_PSP, 1'b1, 32'h3000_0007, 4'hF);
		tick(3);
		chk("main stack aligned", 32'h2000_0000, active_stack_pointer_ff);
		apb(ADDR_CTRL, 1'b1, 32'h3, 4'hF);
		tick(3);
		chk("user thread", 32'h0, {31'h0, privileged_ff});
		chk("process stack", 32'h3000_0004, active_stack_pointer_ff);
		seen_cause = FLT_NONE;
		apb(ADDR_INTERRUPT_PRIORITY_MASK, 1'b1, 32'h1, 4'hF);
		chk("user write refused", 32'h1, {31'h0, er});
		tick(3);
		chk("user fault cause", {30'h0, FLT_PRIV}, {30'h0, seen_cause});
		seen_cause = FLT_NONE;
		apb(ADDR_CTRL, 1'b0, 32'h0, 4'hF);
		chk("user read blocked", 32'h0, rd);
		tick(3);
		chk("user read fault", {30'h0, FLT_PRIV}, {30'h0, seen_cause});
		apb(ADDR_FLAGS, 1'b0, 32'h0, 4'hF);
		chk("user flags view", 32'hF800_0000, rd);
		apb(ADDR_FLAGS, 1'b1, 32'h5000_0000, 4'hF);
		chk("user flags write allowed", 32'h0, {31'h0, er});
		apb(ADDR_FLAGS, 1'b0, 32'h0, 4'hF);
		chk("user flags written", 32'h5000_0000, rd);
		seen_cause = FLT_NONE;
		@(posedge pclk);
		restricted_access <= 1'b1;
		@(posedge pclk);
		restricted_access <= 1'b0;
		tick(3);
		chk("restricted fault", {30'h0, FLT_PRIV}, {30'h0, seen_cause});
		// Exception entry and return
		@(posedge pclk);
		exc_entry <= 1'b1;
		exc_num <= 9'h00B;
		@(posedge pclk);
		exc_entry <= 1'b0;
		tick(3);
		chk("handler mode", 32'h1, {31'h0, handler_ff});
		chk("handler privileged", 32'h1, {31'h0, privileged_ff});
		chk("handler main stack", 32'h2000_0000, active_stack_pointer_ff);
		apb(ADDR_EXCV, 1'b0, 32'h0, 4'hF);
		chk("exception view", 32'h0000_000B, rd);
		apb(ADDR_STATE, 1'b0, 32'h0, 4'hF);
		chk("state handler", 32'h4, rd);
		@(posedge pclk);
		exc_return <= 1'b1;
		@(posedge pclk);
		exc_return <= 1'b0;
		tick(3);
		chk("thread after return", 32'h0, {31'h0, handler_ff});
		chk("user after return", 32'h0, {31'h0, privileged_ff});
		chk("process stack after return", 32'h3000_0004, active_stack_pointer_ff);
		// Second reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		tick(2);
		chk("rereset privileged", 32'h1, {31'h0, privileged_ff});
		chk("rereset stack", 32'h0, active_stack_pointer_ff);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(ADDR_CTRL, 1'b0, 32'h0, 4'hF);
		chk("control after reset", 32'h0, rd);
		final_report();
	end
endmodule
`default_nettype wire
